//--- rtl/oov_pkg.sv
// constants and types for the input overvoltage fault response block
package oov_pkg;

    // ---------------------------------------------------------------
    // register command codes
    // ---------------------------------------------------------------
    localparam logic [7:0]  OOV_ADDR_THRESH    = 8'h55;
    localparam logic [7:0]  OOV_ADDR_REACT     = 8'h56;

    // ---------------------------------------------------------------
    // threshold register layout
    // ---------------------------------------------------------------
    localparam int          OOV_THR_EXP_LSB    = 11;
    localparam int          OOV_THR_EXP_W      = 5;
    localparam int          OOV_MANT_W         = 11;
    localparam int          OOV_EXP_CODE_W     = 3;
    localparam int          OOV_VIN_W          = 16;
    localparam int          OOV_CMP_W          = 18;

    // ---------------------------------------------------------------
    // reaction register layout
    // ---------------------------------------------------------------
    localparam int          OOV_RESP_LSB       = 6;
    localparam int          OOV_RETRY_LSB      = 3;
    localparam int          OOV_DELAY_LSB      = 0;
    localparam logic [1:0]  OOV_RESP_IGNORE    = 2'h0;
    localparam logic [1:0]  OOV_RESP_DELAYED   = 2'h1;
    localparam logic [1:0]  OOV_RESP_IMMED     = 2'h2;
    localparam logic [1:0]  OOV_RESP_UNTIL_CLR = 2'h3;
    localparam logic [2:0]  OOV_RETRY_INFINITE = 3'h7;

    // ---------------------------------------------------------------
    // values after reset
    // ---------------------------------------------------------------
    localparam logic [10:0] OOV_MANT_RST       = 11'h7ff;
    localparam logic [7:0]  OOV_REACT_RST      = 8'h00;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int          OOV_CLK_PERIOD_PS  = 25000;
    localparam int          OOV_MS_PS          = 1000000000;
    localparam int          OOV_CYC_PER_MS     = OOV_MS_PS / OOV_CLK_PERIOD_PS;
    localparam int          OOV_MS_W           = 12;
    localparam int          OOV_DLY1_BASE_MS   = 10;

    // ---------------------------------------------------------------
    // response state machine
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        OOV_ST_RUN,
        OOV_ST_DELAY,
        OOV_ST_RETRY_WAIT,
        OOV_ST_LATCHED,
        OOV_ST_HOLD
    } oov_state_t;

    // shutdown delay in ms for a delay code
    function automatic logic [OOV_MS_W-1:0] oov_dly1_ms(
        input logic [2:0] code
    );
        logic [OOV_MS_W-1:0] base;
        base = OOV_MS_W'(OOV_DLY1_BASE_MS);
        return base << code;
    endfunction : oov_dly1_ms

    // restart interval in ms for a delay code
    function automatic logic [OOV_MS_W-1:0] oov_dly2_ms(
        input logic [2:0] code
    );
        logic [OOV_MS_W-1:0] ms;
        ms = 12'h0fc;
        unique case (code)
            3'h0: ms = 12'h0fc;
            3'h1: ms = 12'h22e;
            3'h2: ms = 12'h39c;
            3'h3: ms = 12'h4ec;
            3'h4: ms = 12'h63c;
            3'h5: ms = 12'h78c;
            3'h6: ms = 12'h8dc;
            3'h7: ms = 12'ha2c;
        endcase
        return ms;
    endfunction : oov_dly2_ms

endpackage : oov_pkg

//--- rtl/oov_ms_timer.sv
// millisecond tick divider and interval countdown
`timescale 1ns/1ps
module oov_ms_timer
    import oov_pkg::*;
#(
    parameter int CYC_PER_MS = OOV_CYC_PER_MS
) (
    // clock and reset
    input  wire logic                mclk_i,
    input  wire logic                srst_i,
    // interval control
    input  wire logic                start_i,
    input  wire logic [OOV_MS_W-1:0] len_ms_i,
    // interval end
    output logic                     done_o
);

    localparam int PRE_W = $clog2(CYC_PER_MS);
    localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(CYC_PER_MS - 1);

    if (CYC_PER_MS < 2) begin : g_bad_div
        $error("CYC_PER_MS must be at least 2");
    end

    logic [PRE_W-1:0]    pre_r;
    logic [OOV_MS_W-1:0] ms_r;
    logic                run_r;

    // ---------------------------------------------------------------
    // countdown, restarted by every start
    // ---------------------------------------------------------------
    // tick count restarts
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pre_r  <= PRE_LOAD;
            ms_r   <= '0;
            run_r  <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin
            pre_r  <= PRE_LOAD;
            ms_r   <= len_ms_i;
            run_r  <= (len_ms_i != '0);
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (run_r) begin
                if (pre_r == '0) begin
                    pre_r <= PRE_LOAD;
                    ms_r  <= ms_r - 1'b1;
                    if (ms_r == OOV_MS_W'(1)) begin
                        run_r  <= 1'b0;
                        done_o <= 1'b1;
                    end
                end else begin
                    pre_r <= pre_r - 1'b1;
                end
            end
        end
    end

endmodule : oov_ms_timer

//--- rtl/oov_fault_resp.sv
// input overvoltage supervision with programmable fault response
`timescale 1ns/1ps

// Notes on behaviour
// - fault while sensed input exceeds threshold
// - eleven-bit writable threshold mantissa
// - top threshold bits read back exponent
// - two-bit response; code 00 ignores fault
// - code 01 waits delay then retries
// - code 10 shuts down immediately, retries
// - code 11 off until fault clears
// - delay field sets both wait times
// - zero to six retries, 7 unlimited
module oov_fault_resp
    import oov_pkg::*;
#(
    parameter int CYC_PER_MS = OOV_CYC_PER_MS
) (
    // clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      srst_i,
    // register command port
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [15:0]               reg_wdata_i,
    output logic      [15:0]               reg_rdata_o,
    output logic                           reg_rvalid_o,
    // exponent from the exponent register
    input  wire logic [OOV_EXP_CODE_W-1:0] exp_code_i,
    // sensed input voltage, same clock
    input  wire logic [OOV_VIN_W-1:0]      vin_i,
    // status and control outputs
    output logic                           ov_fault_o,
    output logic                           output_en_o,
    output logic                           latched_off_o,
    output logic      [2:0]                retry_cnt_o
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [OOV_MANT_W-1:0] mant_r;
    logic [7:0]            react_r;
    logic                  fault_r;
    oov_state_t            state_r;
    oov_state_t            state_nxt;
    logic [2:0]            retry_r;
    logic [2:0]            retry_nxt;
    logic                  tmr_start;
    logic [OOV_MS_W-1:0]   tmr_len;
    logic                  tmr_done;

    logic [1:0]            resp;
    logic [2:0]            retry_lim;
    logic [2:0]            dly_code;
    logic [OOV_CMP_W-1:0]  thr_val;

    assign resp      = react_r[OOV_RESP_LSB +: 2];
    assign retry_lim = react_r[OOV_RETRY_LSB +: 3];
    assign dly_code  = react_r[OOV_DELAY_LSB +: 3];

    // threshold value as mantissa times two to the exponent
    function automatic logic [OOV_CMP_W-1:0] thr_value(
        input logic [OOV_MANT_W-1:0]     mant,
        input logic [OOV_EXP_CODE_W-1:0] expo
    );
        logic [OOV_CMP_W-1:0] wide;
        wide = OOV_CMP_W'(mant);
        return wide << expo;
    endfunction : thr_value

    assign thr_val = thr_value(mant_r, exp_code_i);

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mant_r  <= OOV_MANT_RST;
            react_r <= OOV_REACT_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == OOV_ADDR_THRESH) begin
                mant_r <= reg_wdata_i[OOV_MANT_W-1:0];
            end
            if (reg_addr_i == OOV_ADDR_REACT) begin
                react_r <= reg_wdata_i[7:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    OOV_ADDR_THRESH: reg_rdata_o <= {
                        OOV_THR_EXP_W'(exp_code_i), mant_r};
                    OOV_ADDR_REACT:  reg_rdata_o <= {8'h00, react_r};
                    default:         reg_rdata_o <= '0;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // fault detection
    // ---------------------------------------------------------------
    // strict compare
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= (OOV_CMP_W'(vin_i) > thr_val);
        end
    end

    // ---------------------------------------------------------------
    // response state machine
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        retry_nxt = retry_r;
        tmr_start = 1'b0;
        tmr_len   = oov_dly1_ms(dly_code);
        unique case (state_r)
            OOV_ST_RUN: begin
                if (!fault_r) begin
                    retry_nxt = '0;
                end else begin
                    unique case (resp)
                        OOV_RESP_IGNORE: state_nxt = OOV_ST_RUN;
                        OOV_RESP_DELAYED: begin
                            state_nxt = OOV_ST_DELAY;
                            tmr_start = 1'b1;
                        end
                        OOV_RESP_IMMED: begin
                            tmr_start = 1'b1;
                            tmr_len   = oov_dly2_ms(dly_code);
                            if (retry_lim == OOV_RETRY_INFINITE ||
                                retry_r < retry_lim) begin
                                state_nxt = OOV_ST_RETRY_WAIT;
                            end else begin
                                state_nxt = OOV_ST_LATCHED;
                            end
                        end
                        OOV_RESP_UNTIL_CLR: state_nxt = OOV_ST_HOLD;
                    endcase
                end
            end
            OOV_ST_DELAY: begin
                if (!fault_r) begin
                    state_nxt = OOV_ST_RUN;
                end else if (tmr_done) begin
                    tmr_start = 1'b1;
                    tmr_len   = oov_dly2_ms(dly_code);
                    if (retry_lim == OOV_RETRY_INFINITE ||
                        retry_r < retry_lim) begin
                        state_nxt = OOV_ST_RETRY_WAIT;
                    end else begin
                        state_nxt = OOV_ST_LATCHED;
                    end
                end
            end
            OOV_ST_RETRY_WAIT: begin
                if (tmr_done) begin
                    state_nxt = OOV_ST_RUN;
                    if (retry_lim != OOV_RETRY_INFINITE) begin
                        retry_nxt = retry_r + 3'h1;
                    end
                end
            end
            OOV_ST_LATCHED: state_nxt = OOV_ST_LATCHED;
            OOV_ST_HOLD: begin
                if (!fault_r) begin
                    state_nxt = OOV_ST_RUN;
                end
            end
            default: state_nxt = OOV_ST_LATCHED;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_r <= OOV_ST_RUN;
            retry_r <= '0;
        end else begin
            state_r <= state_nxt;
            retry_r <= retry_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            output_en_o   <= 1'b1;
            latched_off_o <= 1'b0;
            ov_fault_o    <= 1'b0;
            retry_cnt_o   <= '0;
        end else begin
            output_en_o   <= (state_nxt == OOV_ST_RUN) ||
                             (state_nxt == OOV_ST_DELAY);
            latched_off_o <= (state_nxt == OOV_ST_LATCHED);
            ov_fault_o    <= fault_r;
            retry_cnt_o   <= retry_nxt;
        end
    end

    // ---------------------------------------------------------------
    // interval timer
    // ---------------------------------------------------------------
    oov_ms_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .mclk_i   (mclk_i),
        .srst_i   (srst_i),
        .start_i  (tmr_start),
        .len_ms_i (tmr_len),
        .done_o   (tmr_done)
    );

endmodule : oov_fault_resp

//--- testbench/oov_fault_resp_properties.sv
// concurrent checks on the fault response block ports
`timescale 1ns/1ps
module oov_fault_resp_properties
    import oov_pkg::*;
#(
    parameter int CYC_PER_MS = OOV_CYC_PER_MS
) (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        srst_i,
    // register command port
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    // sensed input and exponent
    input wire logic [2:0]  exp_code_i,
    input wire logic [15:0] vin_i,
    // status and control
    input wire logic        ov_fault_o,
    input wire logic        output_en_o,
    input wire logic        latched_off_o,
    input wire logic [2:0]  retry_cnt_o
);
    logic [10:0] mant_r;
    logic [7:0]  react_r;
    logic [1:0]  resp;
    logic        over;
    assign resp = react_r[7:6];
    assign over = {2'b00, vin_i} > ({7'h00, mant_r} << exp_code_i);
    // ------------------------------------------------------------
    // shadow register fields
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i)
            mant_r <= OOV_MANT_RST;
        else if (reg_wr_i && reg_addr_i == OOV_ADDR_THRESH)
            mant_r <= reg_wdata_i[10:0];
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i)
            react_r <= OOV_REACT_RST;
        else if (reg_wr_i && reg_addr_i == OOV_ADDR_REACT)
            react_r <= reg_wdata_i[7:0];
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    a_read_strobe: assert property (
        reg_rvalid_o == $past(reg_rd_i)) else $error("read answer wrong");
    a_thr_exponent: assert property (
        reg_rd_i && reg_addr_i == OOV_ADDR_THRESH |=> reg_rdata_o ==
        {2'b00, $past(exp_code_i), $past(mant_r)}) else $error("thr read");
    a_react_read: assert property (
        reg_rd_i && reg_addr_i == OOV_ADDR_REACT |=>
        reg_rdata_o == {8'h00, $past(react_r)}) else $error("react read");
    a_fault_level: assert property (
        (!reg_wr_i && $stable(vin_i) && $stable(exp_code_i))[*3] |->
        ov_fault_o == over) else $error("fault flag wrong");
    a_ignore_stays_on: assert property (
        resp == OOV_RESP_IGNORE && output_en_o && !reg_wr_i |=>
        output_en_o) else $error("ignore code shut down");
    a_immed_off: assert property (
        resp == OOV_RESP_IMMED && ov_fault_o && !reg_wr_i |->
        ##[0:2] !output_en_o) else $error("no immediate shutdown");
    a_delay_holds: assert property (
        resp == OOV_RESP_DELAYED && output_en_o && $rose(ov_fault_o) |=>
        output_en_o[*8]) else $error("delayed code shut down early");
    a_clear_reenable: assert property (
        resp == OOV_RESP_UNTIL_CLR && !latched_off_o &&
        $fell(ov_fault_o) && !reg_wr_i |-> ##[0:3] output_en_o)
        else $error("output not back on");
    a_hold_off: assert property (
        resp == OOV_RESP_UNTIL_CLR && ov_fault_o && !reg_wr_i |->
        ##[0:2] !output_en_o) else $error("output on during fault");
    a_latch_sticky: assert property (
        latched_off_o |=> latched_off_o && !output_en_o)
        else $error("latched state left");
    a_retry_limit: assert property (
        react_r[5:3] != OOV_RETRY_INFINITE |-> retry_cnt_o <= react_r[5:3])
        else $error("retry count over limit");
    a_infinite_count: assert property (
        react_r[5:3] == OOV_RETRY_INFINITE |-> retry_cnt_o == 3'h0)
        else $error("unlimited retries counted");
endmodule : oov_fault_resp_properties

bind oov_fault_resp oov_fault_resp_properties #(
    .CYC_PER_MS(CYC_PER_MS)
) i_oov_fault_resp_properties (
    .mclk_i(mclk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .exp_code_i(exp_code_i), .vin_i(vin_i),
    .ov_fault_o(ov_fault_o), .output_en_o(output_en_o),
    .latched_off_o(latched_off_o), .retry_cnt_o(retry_cnt_o)
);

//--- testbench/tb.sv
// self-checking testbench for the fault response block
`timescale 1ns/1ps
module tb;
    import oov_pkg::*;
    localparam int CPM = 4;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic        reg_rvalid_o;
    logic [2:0]  exp_code_i = 3'h0;
    logic [15:0] vin_i = 16'h0000;
    logic        ov_fault_o;
    logic        output_en_o;
    logic        latched_off_o;
    logic [2:0]  retry_cnt_o;
    int          mismatches = 0;
    int          num_checks = 0;
    int          n;
    logic [10:0] m;
    logic [7:0]  r;
    logic [17:0] t;
    logic [15:0] exp_q[$];
    int          d2_ms[8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};

    oov_fault_resp #(.CYC_PER_MS(CPM)) i_oov_fault_resp (
        .mclk_i(mclk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .exp_code_i(exp_code_i),
        .vin_i(vin_i), .ov_fault_o(ov_fault_o), .output_en_o(output_en_o),
        .latched_off_o(latched_off_o), .retry_cnt_o(retry_cnt_o)
    );

    always #12.5 mclk_i = ~mclk_i;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input int c, input int ms);
        chk(16'(c >= (ms - 1) * CPM && c <= (ms + 2) * CPM), 16'h0001);
    endtask : rng
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge mclk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        exp_q.push_back(e);
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
    endtask : rd
    task automatic rst();
        @(negedge mclk_i);
        srst_i = 1'b1;
        vin_i = 16'h0000;
        exp_code_i = 3'h0;
        repeat (6) @(negedge mclk_i);
        srst_i = 1'b0;
    endtask : rst
    task automatic wait_en(input logic v, output int c);
        c = 0;
        while (output_en_o !== v && c < 12000) begin
            @(negedge mclk_i);
            c++;
        end
    endtask : wait_en
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // read data against the oldest noted value
    always @(negedge mclk_i) begin
        if (reg_rvalid_o === 1'b1)
            chk(reg_rdata_o, exp_q.pop_front());
    end

    initial begin
        #2250000;
        mismatches++;
        close_out();
    end

    // ------------------------------------------------------------
    // stimulus and checks
    // ------------------------------------------------------------
    initial begin
        void'($urandom(65462));
        rst();
        exp_code_i = 3'h5;
        rd(OOV_ADDR_THRESH, {5'h05, 11'h7ff});
        rd(OOV_ADDR_REACT, 16'h0000);
        rd(8'h57, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            m = 11'($urandom);
            exp_code_i = 3'(i);
            wr(OOV_ADDR_THRESH, {5'h1f, m});
            rd(OOV_ADDR_THRESH, {2'b00, 3'(i), m});
        end
        r = 8'($urandom);
        wr(OOV_ADDR_REACT, {8'hff, r});
        wr(8'h57, 16'hffff);
        rd(OOV_ADDR_REACT, {8'h00, r});
        wr(OOV_ADDR_REACT, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            m = 11'($urandom);
            exp_code_i = 3'($urandom % 5);
            t = 18'(m) << exp_code_i;
            wr(OOV_ADDR_THRESH, {5'h00, m});
            for (int k = 0; k < 3; k++) begin
                vin_i = (k == 2) ? 16'($urandom) : t[15:0] + 16'(k);
                repeat (4) @(negedge mclk_i);
                chk({15'h0, ov_fault_o}, {15'h0, {2'b00, vin_i} > t});
                chk({15'h0, output_en_o}, 16'h0001);
            end
        end
        rst();
        wr(OOV_ADDR_THRESH, 16'h0064);
        wr(OOV_ADDR_REACT, 16'h0090);
        vin_i = 16'h00c8;
        wait_en(1'b0, n);
        chk(16'(n <= 4), 16'h0001);
        for (int i = 1; i <= 2; i++) begin
            wait_en(1'b1, n);
            rng(n, 252);
            chk({13'h0, retry_cnt_o}, 16'(i));
            wait_en(1'b0, n);
        end
        repeat (3) @(negedge mclk_i);
        chk({15'h0, latched_off_o}, 16'h0001);
        vin_i = 16'h0000;
        repeat (20) @(negedge mclk_i);
        chk({15'h0, output_en_o}, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            rst();
            wr(OOV_ADDR_THRESH, 16'h0064);
            wr(OOV_ADDR_REACT, {8'h00, 5'b01001, 3'(c)});
            vin_i = 16'h00c8;
            wait_en(1'b0, n);
            rng(n, 10 << c);
            wait_en(1'b1, n);
            rng(n, d2_ms[c]);
        end
        wait_en(1'b0, n);
        rng(n, 1280);
        repeat (3) @(negedge mclk_i);
        chk({15'h0, latched_off_o}, 16'h0001);
        rst();
        wr(OOV_ADDR_THRESH, 16'h0064);
        wr(OOV_ADDR_REACT, 16'h00c0);
        vin_i = 16'h00c8;
        repeat (100) @(negedge mclk_i);
        chk({15'h0, output_en_o}, 16'h0000);
        vin_i = 16'h0000;
        wait_en(1'b1, n);
        chk(16'(n <= 5), 16'h0001);
        rst();
        wr(OOV_ADDR_THRESH, 16'h0064);
        wr(OOV_ADDR_REACT, 16'h00b8);
        vin_i = 16'h00c8;
        repeat (2200) @(negedge mclk_i);
        chk({12'h0, latched_off_o, retry_cnt_o}, 16'h0000);
        close_out();
    end
endmodule : tb
